// ===== hw/ris_sequencer.sv
// Reset and interrupt sequencer of an 8-bit processor core
`timescale 1ns/1ps
module ris_sequencer
    import ris_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Bidirectional reset pin and internal reset
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_n_o,
    output logic int_rst_o,
    input wire logic int_rst_req_i,
    // Mode straps, asynchronous
    input wire logic irq_hv_i,
    input wire logic port_x_i,
    input wire logic port_y_i,
    // Execution unit
    input wire ris_pkg::ris_core_t core_i,
    input wire logic instr_last_i,
    input wire logic trap_fetch_i,
    input wire logic rti_i,
    input wire logic clear_mask_op_i,
    input wire logic tap_i,
    input wire logic sei_i,
    input wire logic wait_i,
    input wire logic stop_i,
    output logic core_run_o,
    output logic clk_run_o,
    output ris_pkg::ris_core_t restore_o,
    output logic pc_ld_o,
    output logic regs_ld_o,
    output logic [15:0] sp_o,
    output logic [7:0] idx_hi_o,
    output logic [7:0] flag_register_o,
    // Requests from the system integration unit
    input wire logic periph_request_line_i,
    input wire logic [6:0] req_code_i,
    input wire logic stop_wake_i,
    // Memory port
    output ris_pkg::ris_mem_t mem_o,
    input wire logic [7:0] mem_rdata_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import ris_pkg::*;

    ris_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [15:0] sp_reg, sp_next, pc_stk_reg, pc_stk_next;
    logic [7:0] idx_hi_reg, idx_hi_next, ccr_reg, ccr_next;
    logic [7:0] buf_reg, buf_next;
    logic [6:0] code_reg, code_next;
    logic mon_reg, mon_next, src_reg, src_next;
    logic lock_reg, lock_next, req_q_reg, req_q_next;
    logic pin_prev_reg, pin_prev_next;
    ris_mem_t mem_reg, mem_next;
    ris_core_t rest_reg, rest_next;
    logic pc_ld_reg, pc_ld_next, regs_ld_reg, regs_ld_next;
    logic [31:0] rdata_reg, rdata_next;
    logic pin_s1, pin_s2, hv_s1, hv_s2, px_s1, px_s2;
    logic py_s1, py_s2, wk_s1, wk_s2;
    logic take, swrst, in_rst;
    logic [6:0] take_code;
    logic [15:0] take_pc, vec_addr;

    // Asynchronous pins cross on two flops
    always_ff @(posedge sys_clk_i) begin
        pin_s1 <= rst_pin_i;
        pin_s2 <= pin_s1;
        hv_s1 <= irq_hv_i;
        hv_s2 <= hv_s1;
        px_s1 <= port_x_i;
        px_s2 <= px_s1;
        py_s1 <= port_y_i;
        py_s2 <= py_s1;
        wk_s1 <= stop_wake_i;
        wk_s2 <= wk_s1;
    end

    assign in_rst = (state_reg == RIS_PINDRV) ||
                    (state_reg == RIS_RSTHOLD) ||
                    (state_reg == RIS_EXTRST);

    // async assert
    // Raw pin gates reset so it acts with no clock running
    assign int_rst_o = !rst_pin_i || in_rst;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_n_o = (state_reg != RIS_PINDRV);
    assign core_run_o = (state_reg == RIS_RUN);
    assign clk_run_o = (state_reg != RIS_STOP);
    assign restore_o = rest_reg;
    assign pc_ld_o = pc_ld_reg;
    assign regs_ld_o = regs_ld_reg;
    assign sp_o = sp_reg;
    assign idx_hi_o = idx_hi_reg;
    assign flag_register_o = ccr_reg;
    assign mem_o = mem_reg;
    assign reg_rdata_o = rdata_reg;

    always_comb begin
        vec_addr = VEC_TOP - {8'h00, code_reg, 1'b0};
        if (mon_reg) begin
            vec_addr[VEC_MON_BIT] = 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sp_next = sp_reg;
        pc_stk_next = pc_stk_reg;
        idx_hi_next = idx_hi_reg;
        ccr_next = ccr_reg;
        buf_next = buf_reg;
        code_next = code_reg;
        mon_next = mon_reg;
        src_next = src_reg;
        lock_next = lock_reg;
        rest_next = rest_reg;
        mem_next = '0;
        pc_ld_next = 1'b0;
        regs_ld_next = 1'b0;
        rdata_next = '0;
        take = 1'b0;
        take_code = CODE_TRAP;
        take_pc = core_i.pc;
        swrst = 1'b0;
        req_q_next = periph_request_line_i;
        pin_prev_next = pin_s2;

        if (pin_s2 && !pin_prev_reg) begin
            mon_next = hv_s2 && px_s2 && !py_s2;
        end

        if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            swrst = reg_wdata_i[CTRL_SWRST_BIT];
            if (reg_wdata_i[CTRL_CLRSRC_BIT]) begin
                src_next = 1'b0;
            end
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_STATUS: begin
                    rdata_next[STAT_SRC_BIT] = src_reg;
                    rdata_next[STAT_MON_BIT] = mon_reg;
                    rdata_next[STAT_I_BIT] = ccr_reg[CCR_I_BIT];
                    rdata_next[STAT_WAIT_BIT] = (state_reg == RIS_WAIT);
                    rdata_next[STAT_STOP_BIT] = (state_reg == RIS_STOP);
                    rdata_next[STAT_STATE_LSB +: 4] = state_reg;
                end
                REG_SP: rdata_next[15:0] = sp_reg;
                REG_VEC: rdata_next[6:0] = code_reg;
                default: rdata_next = '0;
            endcase
        end

        if (trap_fetch_i) begin
            lock_next = 1'b1;
        end

        case (state_reg)
            RIS_RUN: begin
                if (clear_mask_op_i) begin
                    ccr_next[CCR_I_BIT] = 1'b0;
                end
                if (tap_i) begin
                    ccr_next = core_i.acc;
                end
                if (sei_i) begin
                    ccr_next[CCR_I_BIT] = 1'b1;
                end
                if (instr_last_i) begin
                    if (lock_reg || trap_fetch_i) begin
                        take = 1'b1;
                    end else if (req_q_reg && !ccr_reg[CCR_I_BIT]) begin
                        take = 1'b1;
                        take_code = req_code_i;
                        take_pc = core_i.pc - 16'h0001;
                    end else if (rti_i) begin
                        state_next = RIS_PULL;
                        cnt_next = '0;
                    end else if (wait_i) begin
                        state_next = RIS_WAIT;
                    end else if (stop_i) begin
                        state_next = RIS_STOP;
                    end
                end
            end
            RIS_WAIT: begin
                if (req_q_reg && !ccr_reg[CCR_I_BIT]) begin
                    take = 1'b1;
                    take_code = req_code_i;
                    take_pc = core_i.pc - 16'h0001;
                end
            end
            RIS_STOP: begin
                if (wk_s2 && req_q_reg && !ccr_reg[CCR_I_BIT]) begin
                    take = 1'b1;
                    take_code = req_code_i;
                    take_pc = core_i.pc - 16'h0001;
                end
            end
            RIS_PUSH: begin
                mem_next.wr = 1'b1;
                mem_next.addr = sp_reg;
                sp_next = sp_reg - 16'h0001;
                cnt_next = cnt_reg + 4'h1;
                case (cnt_reg)
                    4'h0: mem_next.wdata = pc_stk_reg[7:0];
                    4'h1: mem_next.wdata = pc_stk_reg[15:8];
                    4'h2: mem_next.wdata = core_i.idx_lo;
                    4'h3: mem_next.wdata = core_i.acc;
                    default: mem_next.wdata = ccr_reg;
                endcase
                if (cnt_reg == 4'h4) begin
                    ccr_next[CCR_I_BIT] = 1'b1;
                    state_next = RIS_VECTOR;
                    cnt_next = '0;
                end
            end
            RIS_VECTOR: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == 4'h0) begin
                    mem_next.rd = 1'b1;
                    mem_next.addr = vec_addr;
                end else if (cnt_reg == 4'h1) begin
                    mem_next.rd = 1'b1;
                    mem_next.addr = vec_addr | 16'h0001;
                end else if (cnt_reg == 4'h2) begin
                    // Read data trail the registered strobe by a cycle
                    buf_next = mem_rdata_i;
                end else begin
                    rest_next.pc = {buf_reg, mem_rdata_i};
                    pc_ld_next = 1'b1;
                    lock_next = 1'b0;
                    state_next = RIS_RUN;
                    cnt_next = '0;
                end
            end
            RIS_PULL: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg < 4'h5) begin
                    mem_next.rd = 1'b1;
                    mem_next.addr = sp_reg + 16'h0001;
                    sp_next = sp_reg + 16'h0001;
                end
                // Each byte lands two cycles after its read is issued
                case (cnt_reg)
                    4'h2: ccr_next = mem_rdata_i;
                    4'h3: rest_next.acc = mem_rdata_i;
                    4'h4: rest_next.idx_lo = mem_rdata_i;
                    4'h5: buf_next = mem_rdata_i;
                    4'h6: begin
                        rest_next.pc = {buf_reg, mem_rdata_i};
                        pc_ld_next = 1'b1;
                        regs_ld_next = 1'b1;
                        state_next = RIS_RUN;
                        cnt_next = '0;
                    end
                    default: ;
                endcase
            end
            RIS_PINDRV: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == 4'(RST_DRIVE_CYC - 1)) begin
                    state_next = RIS_RSTHOLD;
                    cnt_next = '0;
                end
            end
            RIS_RSTHOLD: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == 4'(RST_HOLD_CYC - 1)) begin
                    cnt_next = '0;
                    if (!pin_s2) begin
                        state_next = RIS_EXTRST;
                    end else begin
                        src_next = 1'b1;
                        state_next = RIS_VECTOR;
                        code_next = CODE_RESET;
                    end
                end
            end
            RIS_EXTRST: begin
                cnt_next = '0;
                if (pin_s2) begin
                    state_next = RIS_VECTOR;
                    code_next = CODE_RESET;
                end
            end
            default: begin
                state_next = RIS_EXTRST;
                cnt_next = '0;
            end
        endcase

        if (take) begin
            state_next = RIS_PUSH;
            cnt_next = '0;
            code_next = take_code;
            pc_stk_next = take_pc;
        end

        if (!in_rst) begin
            if (!pin_s2) begin
                state_next = RIS_EXTRST;
                cnt_next = '0;
            end else if (int_rst_req_i || swrst) begin
                state_next = RIS_PINDRV;
                cnt_next = '0;
            end
        end
        if (state_next == RIS_PINDRV || state_next == RIS_RSTHOLD ||
            state_next == RIS_EXTRST) begin
            sp_next = SP_INIT;
            idx_hi_next = 8'h00;
            ccr_next = CCR_INIT;
            lock_next = 1'b0;
            code_next = CODE_RESET;
            mem_next = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= RIS_EXTRST;
            cnt_reg <= '0;
            sp_reg <= SP_INIT;
            pc_stk_reg <= '0;
            idx_hi_reg <= 8'h00;
            ccr_reg <= CCR_INIT;
            buf_reg <= 8'h00;
            code_reg <= CODE_RESET;
            mon_reg <= 1'b0;
            src_reg <= 1'b0;
            lock_reg <= 1'b0;
            req_q_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
            mem_reg <= '0;
            rest_reg <= '0;
            pc_ld_reg <= 1'b0;
            regs_ld_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sp_reg <= sp_next;
            pc_stk_reg <= pc_stk_next;
            idx_hi_reg <= idx_hi_next;
            ccr_reg <= ccr_next;
            buf_reg <= buf_next;
            code_reg <= code_next;
            mon_reg <= mon_next;
            src_reg <= src_next;
            lock_reg <= lock_next;
            req_q_reg <= req_q_next;
            pin_prev_reg <= pin_prev_next;
            mem_reg <= mem_next;
            rest_reg <= rest_next;
            pc_ld_reg <= pc_ld_next;
            regs_ld_reg <= regs_ld_next;
            rdata_reg <= rdata_next;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_pin_drive_len: assert property (
        $fell(rst_pin_oe_n_o) |-> !rst_pin_oe_n_o[*8] ##1
        !rst_pin_oe_n_o[*8] ##1 rst_pin_oe_n_o)
        else $error("reset pin not driven for 16 cycles");
    a_hold_len: assert property (
        $rose(state_reg == RIS_RSTHOLD) |-> (int_rst_o &&
        rst_pin_oe_n_o)[*8] ##1 (int_rst_o && rst_pin_oe_n_o)[*8]
        ##1 state_reg != RIS_RSTHOLD)
        else $error("internal reset hold not 16 cycles");
    a_src_flag_set: assert property (
        state_reg == RIS_RSTHOLD && cnt_reg == 4'hF && pin_s2
        |=> src_reg && state_reg == RIS_VECTOR)
        else $error("internal reset source flag not set");
    a_reset_init: assert property (
        $past(state_reg) == RIS_EXTRST && state_reg == RIS_VECTOR
        |-> sp_reg == 16'h00FF && idx_hi_reg == 8'h00 &&
        ccr_reg[CCR_I_BIT])
        else $error("core state wrong on reset exit");
    a_vec_mon_bit: assert property (
        state_reg == RIS_VECTOR && cnt_reg == 4'h0
        |=> mem_o.rd && mem_o.addr[8] == !mon_reg &&
        mem_o.addr[0] == 1'b0)
        else $error("vector address bit 8 wrong for mode");
    a_flags_push: assert property (
        state_reg == RIS_PUSH && cnt_reg == 4'h4
        |=> mem_o.wr && mem_o.wdata == $past(ccr_reg) &&
        ccr_reg[CCR_I_BIT])
        else $error("flags not pushed before mask set");
    a_mask_gate: assert property (
        state_reg == RIS_RUN && instr_last_i && ccr_reg[CCR_I_BIT] &&
        !lock_reg && !trap_fetch_i |=> state_reg != RIS_PUSH)
        else $error("masked request was taken");
    a_vector_time: assert property (
        $rose(state_reg == RIS_PUSH) |-> ##5 state_reg == RIS_VECTOR
        ##4 pc_ld_o && state_reg == RIS_RUN)
        else $error("vector not loaded after stacking");
    a_pull_len: assert property (
        $rose(state_reg == RIS_PULL) |-> ##7 regs_ld_o && pc_ld_o)
        else $error("return did not restore registers");

    c_ext_reset: cover property (
        state_reg == RIS_EXTRST ##1 state_reg == RIS_VECTOR);
    c_int_reset: cover property ($rose(src_reg));
    c_irq_entry: cover property (
        $rose(state_reg == RIS_PUSH) && code_reg != CODE_TRAP);
    c_return: cover property ($rose(state_reg == RIS_PULL));
endmodule // ris_sequencer

// ===== hw/ris_pkg.sv
// Constants and carrier types for the reset and interrupt sequencer
package ris_pkg;
    // Reset pin timing in bus clock cycles
    localparam int RST_DRIVE_CYC = 16;
    localparam int RST_HOLD_CYC = 16;
    // Vector table and initial core state
    localparam logic [15:0] VEC_TOP = 16'hFFFE;
    localparam logic [15:0] SP_INIT = 16'h00FF;
    localparam int VEC_MON_BIT = 8;
    localparam int CCR_I_BIT = 3;
    localparam logic [7:0] CCR_INIT = 8'h08;
    localparam logic [6:0] CODE_RESET = 7'h00;
    localparam logic [6:0] CODE_TRAP = 7'h01;
    // Software register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SP = 4'h8;
    localparam logic [3:0] REG_VEC = 4'hC;
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_CLRSRC_BIT = 1;
    localparam int STAT_SRC_BIT = 0;
    localparam int STAT_MON_BIT = 1;
    localparam int STAT_I_BIT = 2;
    localparam int STAT_WAIT_BIT = 3;
    localparam int STAT_STOP_BIT = 4;
    localparam int STAT_STATE_LSB = 8;

    typedef enum logic [3:0] {
        RIS_RUN = 4'h0,
        RIS_PINDRV = 4'h1,
        RIS_RSTHOLD = 4'h2,
        RIS_EXTRST = 4'h3,
        RIS_VECTOR = 4'h4,
        RIS_PUSH = 4'h5,
        RIS_PULL = 4'h6,
        RIS_WAIT = 4'h7,
        RIS_STOP = 4'h8
    } ris_state_t;

    // Core registers exchanged with the execution unit
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] idx_lo;
    } ris_core_t;

    // One memory access per cycle
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ris_mem_t;
endpackage

// ===== tb/ris_mem_model.sv
// Behavioural memory behind the sequencer's stack and vector port
`timescale 1ns/1ps
module ris_mem_model
    import ris_pkg::*;
(
    input wire logic sys_clk_i,
    input wire ris_pkg::ris_mem_t mem_i,
    output logic [7:0] rdata_o
);
    import ris_pkg::*;
    logic [7:0] mem [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hA5 ^ i[7:0];
    end
    // Data valid only after a read; otherwise it toggles
    always @(posedge sys_clk_i) begin
        if (mem_i.wr)
            mem[mem_i.addr] <= mem_i.wdata;
        rdata_o <= mem_i.rd ? mem[mem_i.addr] : ~rdata_o;
    end
endmodule // ris_mem_model

// ===== tb/tb.sv
// Self-checking bench for the reset and interrupt sequencer
`timescale 1ns/1ps
module tb;
    import ris_pkg::*;
    logic clk = 0, rst_n = 0, ext_low = 0, last = 0, return_from_trap = 0, clear_mask_op = 0;
    logic req = 0, wr = 0, rd = 0, irq_req = 0, hv = 0, px = 1, py = 0;
    logic trap = 0, tap = 0, sei = 0, wt = 0, stp = 0, wake = 0;
    logic oe_n, irst, run, crun, pc_ld, regs_ld;
    logic [6:0] code = 7'h02;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [15:0] sp, va, pm1;
    logic [7:0] xh, fl, mrd;
    ris_core_t core = '0, rest;
    ris_mem_t mem;
    logic [15:0] exp_q[$];
    int err_total = 0, n_tests = 0, cyc = 0, n;
    // Open-drain reset pin with pull-up
    wire pin = ~ext_low & oe_n;

    ris_sequencer u_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .rst_pin_i(pin), .rst_pin_o(), .rst_pin_oe_n_o(oe_n),
        .int_rst_o(irst), .int_rst_req_i(irq_req), .irq_hv_i(hv),
        .port_x_i(px), .port_y_i(py), .core_i(core),
        .instr_last_i(last), .trap_fetch_i(trap), .rti_i(return_from_trap),
        .clear_mask_op_i(clear_mask_op), .tap_i(tap), .sei_i(sei),
        .wait_i(wt), .stop_i(stp), .core_run_o(run),
        .clk_run_o(crun), .restore_o(rest), .pc_ld_o(pc_ld),
        .regs_ld_o(regs_ld), .sp_o(sp), .idx_hi_o(xh),
        .flag_register_o(fl), .periph_request_line_i(req),
        .req_code_i(code), .stop_wake_i(wake), .mem_o(mem),
        .mem_rdata_i(mrd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
    ris_mem_model u_mem (.sys_clk_i(clk), .mem_i(mem), .rdata_o(mrd));

    always #10 clk = ~clk;

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rreg(logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_run(int lim);
        for (int i = 0; i < lim && run !== 1'b1; i++)
            @(posedge clk);
        #1;
    endtask
    task automatic boundary(logic r);
        @(posedge clk);
        last <= 1'b1;
        return_from_trap <= r;
        @(posedge clk);
        last <= 1'b0;
        return_from_trap <= 1'b0;
        #1 wait_run(30);
    endtask

    // Every program counter load against the oldest note
    always @(posedge clk) begin
        if (pc_ld === 1'b1)
            chk("pc_load", rest.pc, exp_q.size() ? exp_q.pop_front() : 'x);
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        void'($urandom(77));
        exp_q.push_back(16'h5B5A);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(60);
        chk("sp", sp, SP_INIT);
        chk("idx_hi", xh, 8'h00);
        chk("mask", fl[CCR_I_BIT], 1'b1);
        rreg(4'h2, v);
        chk("unmapped", v, 32'h0);
        $display("reset test done");
        // request at a boundary while masked
        @(posedge clk);
        req <= 1'b1;
        boundary(1'b0);
        repeat (4) @(posedge clk);
        chk("masked", {run, pc_ld}, 2'b10);
        @(posedge clk);
        clear_mask_op <= 1'b1;
        @(posedge clk);
        clear_mask_op <= 1'b0;
        req <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            code <= 7'($urandom_range(127, 2));
            core <= '{pc: 16'($urandom), acc: 8'($urandom), idx_lo: 8'h3C};
            req <= 1'b1;
            #1 va = 16'hFFFE - {8'h00, code, 1'b0};
            pm1 = core.pc - 16'h0001;
            exp_q.push_back({va[7:0] ^ 8'hA5, (va[7:0] | 8'h01) ^ 8'hA5});
            boundary(1'b0);
            req <= 1'b0;
            chk("push_pcl", u_mem.mem[16'h00FF], pm1[7:0]);
            chk("push_pch", u_mem.mem[16'h00FE], pm1[15:8]);
            chk("push_x", u_mem.mem[16'h00FD], 8'h3C);
            chk("push_a", u_mem.mem[16'h00FC], core.acc);
            chk("push_i", u_mem.mem[16'h00FB][3], 1'b0);
            chk("sp_in", sp, 16'h00FA);
            chk("mask_in", fl[CCR_I_BIT], 1'b1);
            exp_q.push_back(pm1);
            boundary(1'b1);
            chk("sp_out", sp, 16'h00FF);
            chk("mask_out", fl[CCR_I_BIT], 1'b0);
            chk("rest_a", rest.acc, core.acc);
            chk("rest_x", rest.idx_lo, 8'h3C);
        end
        $display("interrupt test done");
        // Mask writers: set, load from accumulator, clear
        @(posedge clk);
        sei <= 1'b1;
        @(posedge clk);
        sei <= 1'b0;
        tap <= 1'b1;
        #1 chk("sei", fl[CCR_I_BIT], 1'b1);
        @(posedge clk);
        tap <= 1'b0;
        clear_mask_op <= 1'b1;
        #1 chk("tap", fl, core.acc);
        @(posedge clk);
        clear_mask_op <= 1'b0;
        // Trap outranks a pending request, stacks PC unchanged
        exp_q.push_back(16'h5958);
        @(posedge clk);
        trap <= 1'b1;
        req <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        boundary(1'b0);
        req <= 1'b0;
        chk("trap_pcl", u_mem.mem[16'h00FF], core.pc[7:0]);
        rreg(REG_VEC, v);
        chk("trap_code", v, {25'h0, CODE_TRAP});
        exp_q.push_back(core.pc);
        boundary(1'b1);
        // Stop holds until a capable module wakes it
        @(posedge clk);
        code <= 7'($urandom_range(127, 2));
        stp <= 1'b1;
        last <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        last <= 1'b0;
        req <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("stop_hold", {crun, run}, 2'b00);
        va = 16'hFFFE - {8'h00, code, 1'b0};
        exp_q.push_back({va[7:0] ^ 8'hA5, (va[7:0] | 8'h01) ^ 8'hA5});
        @(posedge clk);
        wake <= 1'b1;
        #1 wait_run(30);
        req <= 1'b0;
        wake <= 1'b0;
        chk("stop_wake", crun, 1'b1);
        exp_q.push_back(core.pc - 16'h0001);
        boundary(1'b1);
        // Wait wakes on an enabled request alone
        @(posedge clk);
        wt <= 1'b1;
        last <= 1'b1;
        @(posedge clk);
        wt <= 1'b0;
        last <= 1'b0;
        req <= 1'b1;
        #1 chk("wait_state", {crun, run}, 2'b10);
        exp_q.push_back({va[7:0] ^ 8'hA5, (va[7:0] | 8'h01) ^ 8'hA5});
        wait_run(30);
        req <= 1'b0;
        exp_q.push_back(core.pc - 16'h0001);
        boundary(1'b1);
        $display("trap and low power test done");
        exp_q.push_back(16'h5B5A);
        @(posedge clk);
        wr <= 1'b1;
        addr <= REG_CTRL;
        wdata <= 32'h1;
        @(posedge clk);
        wr <= 1'b0;
        n = 0;
        repeat (60) begin
            @(posedge clk);
            n += (oe_n === 1'b0);
        end
        chk("pin_low", n, 16);
        rreg(REG_STATUS, v);
        chk("src", v[STAT_SRC_BIT], 1'b1);
        chk("sp_rst", sp, SP_INIT);
        chk("mask_rst", fl[CCR_I_BIT], 1'b1);
        $display("internal reset test done");
        exp_q.push_back(16'h5B5A);
        @(posedge clk);
        ext_low <= 1'b1;
        #1 chk("async", irst, 1'b1);
        repeat (4) @(posedge clk);
        ext_low <= 1'b0;
        #1 wait_run(60);
        chk("vec_left", exp_q.size(), 0);
        $display("external reset test done");
        summarize();
    end
endmodule // tb
